// ### inc/swml_regs.svh
`ifndef SWML_REGS_SVH
`define SWML_REGS_SVH

// ==========================================================
// Configuration byte layout
`define SWML_CFG_RESET      4'h0
`define SWML_CFG_APU_BIT    0
`define SWML_CFG_PDN_BIT    1
`define SWML_CFG_SPU_BIT    2
`define SWML_CFG_ODS_BIT    3
`define SWML_CFG_READ_HIGH  4'h0

// ==========================================================
// Command codes
`define SWML_CMD_DEV_RESET  8'hF0
`define SWML_CMD_WRITE_CFG  8'hC3
`define SWML_CMD_SET_PTR    8'hB4
`define SWML_CMD_ADJ_PORT   8'hA5
`define SWML_CMD_LINE_RST   8'hA1
`define SWML_CMD_LINE_BIT   8'hA2
`define SWML_CMD_LINE_WRB   8'hA3
`define SWML_CMD_LINE_RDB   8'hA4

// ==========================================================
// Read pointer positions and set-pointer parameters
`define SWML_PTR_CONFIG     2'h0
`define SWML_PTR_STATUS     2'h1
`define SWML_PTR_RDATA      2'h2
`define SWML_PTR_PORT       2'h3
`define SWML_PAR_CONFIG     8'h30
`define SWML_PAR_STATUS     8'h31
`define SWML_PAR_RDATA      8'h32
`define SWML_PAR_PORT       8'h33

// ==========================================================
// Fixed pullup length in a reset cycle
`define SWML_CLK_NS         20
`define SWML_FIXED_STD_NS   2500
`define SWML_FIXED_OD_NS    500
`define SWML_FIXED_STD_CYC  ((`SWML_FIXED_STD_NS + `SWML_CLK_NS - 1) / `SWML_CLK_NS)
`define SWML_FIXED_OD_CYC   ((`SWML_FIXED_OD_NS + `SWML_CLK_NS - 1) / `SWML_CLK_NS)

`endif

// ### inc/swml_pkg.sv
package swml_pkg;

  typedef enum logic [2:0]
  {
    PU_IDLE   = 3'b000,
    PU_WAIT   = 3'b001,
    PU_ACTIVE = 3'b010,
    PU_FIXED  = 3'b011,
    PU_SWAIT  = 3'b100,
    PU_STRONG = 3'b101
  } swml_pu_e;

  typedef struct packed
  {
    logic       cfgApu;
    logic       cfgPdn;
    logic       cfgSpu;
    logic       cfgOds;
    logic [1:0] readPtr;
    logic [7:0] rdData;
    logic       cmdAck;
    logic       cmdNack;
    logic       lineGo;
    logic       lineAbort;
    logic       cfgWritten;
    swml_pu_e   puState;
    logic [7:0] puCount;
    logic [1:0] apuThrSync;
    logic [1:0] vihThrSync;
    logic [1:0] sleepNSync;
    logic       resistorOn;
    logic       xtorOn;
    logic       holdLow;
    logic       sleeping;
  } swml_state_s;

endpackage

// ### src/swml_line_config.sv
`timescale 1ns/1ns
`include "swml_regs.svh"
// Contract
// - Four readable registers chosen by a pointer set by the last command.
// - Any device reset leaves configuration reading zero.
// - Configuration write accepted only if upper nibble is inverse of lower.
// - Configuration reads zero in upper nibble, settings in lower nibble.
// - Bits: speed 3, strong pullup 2, power-down 1, active pullup 0.
// - Settings combine freely; strong pullup bit self-clears when it ends.
// - Active pullup transistor on above threshold until slot end.
// - No active pullup on rising edge during short recovery.
// - Fixed pullup in reset cycle: 2.5 us standard, 0.5 us overdrive.
// - Power-down removes resistor, holds line low, refuses line traffic.
// - Sleep input low powers down; line still follows power-down bit.
// - Strong pullup engages at input-high or active threshold per setting.
// - Strong pullup ends on line command, bit cleared, or device reset.
// - Strong pullup never changes the stored active pullup bit.
// - Speed bit selects standard (0) or overdrive (1) line timing.
// - Speed zero then line reset returns everything to standard speed.
// - Device reset command clears configuration and pullup state and aborts line traffic.
// - Invalid command or parameter byte is not acknowledged.
module swml_line_config
  import swml_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Command stream from the host interface
  input  wire logic       cmdValid,
  input  wire logic [7:0] cmdCode,
  input  wire logic [7:0] cmdParam,
  output logic            cmdAck,
  output logic            cmdNack,
  // Register read port
  input  wire logic       rdStrobe,
  input  wire logic [7:0] statusIn,
  input  wire logic [7:0] readDataIn,
  input  wire logic [7:0] portCfgIn,
  output logic [7:0]      rdData,
  output logic [1:0]      readPtr,
  // Line engine handshake
  input  wire logic       riseStart,
  input  wire logic       resetRiseStart,
  input  wire logic       slotEnd,
  input  wire logic       shortRecovery,
  output logic            lineGo,
  output logic            lineAbort,
  output logic            overdriveSpeedSelect,
  output logic            cfgWritten,
  // Line pins and comparators
  input  wire logic       activePullupThreshold,
  input  wire logic       inputHighThreshold,
  input  wire logic       sleepNInput,
  output logic            linePullupResistor,
  output logic            pullupTransistorOn,
  output logic            lineHoldLow,
  output logic            deviceSleep
);

  swml_state_s st_ff;
  swml_state_s nxt_st;

  // Reset value as an indexable constant
  localparam logic [3:0] cfgResetVal = `SWML_CFG_RESET;

  // ==========================================================
  // Helpers
  function automatic logic nibbleOk(input logic [7:0] b);
    nibbleOk = (b[7:4] == ~b[3:0]);
  endfunction

  function automatic logic isLineCmd(input logic [7:0] c);
    isLineCmd = (c == `SWML_CMD_LINE_RST) || (c == `SWML_CMD_LINE_BIT) ||
                (c == `SWML_CMD_LINE_WRB) || (c == `SWML_CMD_LINE_RDB);
  endfunction

  logic       apuAbove;
  logic       vihAbove;
  logic       sleepN;
  logic       strongEnd;
  logic       cmdLine;
  logic       cmdReset;
  logic [7:0] fixedLen;

  assign apuAbove = st_ff.apuThrSync[1];
  assign vihAbove = st_ff.vihThrSync[1];
  assign sleepN   = st_ff.sleepNSync[1];
  assign cmdLine  = cmdValid && isLineCmd(cmdCode);
  assign cmdReset = cmdValid && (cmdCode == `SWML_CMD_DEV_RESET);

  assign fixedLen = st_ff.cfgOds ? 8'(`SWML_FIXED_OD_CYC) : 8'(`SWML_FIXED_STD_CYC);

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_st            = st_ff;
    strongEnd         = 1'b0;
    nxt_st.cmdAck     = 1'b0;
    nxt_st.cmdNack    = 1'b0;
    nxt_st.lineGo     = 1'b0;
    nxt_st.lineAbort  = 1'b0;
    nxt_st.cfgWritten = 1'b0;

    // Pin synchronisers
    nxt_st.apuThrSync = {st_ff.apuThrSync[0], activePullupThreshold};
    nxt_st.vihThrSync = {st_ff.vihThrSync[0], inputHighThreshold};
    nxt_st.sleepNSync = {st_ff.sleepNSync[0], sleepNInput};

    // Read port
    if (rdStrobe)
    begin
      case (st_ff.readPtr)
        `SWML_PTR_CONFIG: nxt_st.rdData = {`SWML_CFG_READ_HIGH, st_ff.cfgOds,
                                           st_ff.cfgSpu, st_ff.cfgPdn, st_ff.cfgApu};
        `SWML_PTR_STATUS: nxt_st.rdData = statusIn;
        `SWML_PTR_RDATA:  nxt_st.rdData = readDataIn;
        `SWML_PTR_PORT:   nxt_st.rdData = portCfgIn;
        default:          nxt_st.rdData = 8'h00;
      endcase
    end

    // Command decode
    if (cmdValid)
    begin
      case (cmdCode)
        `SWML_CMD_WRITE_CFG:
        begin
          if (nibbleOk(cmdParam))
          begin
            nxt_st.cfgApu     = cmdParam[`SWML_CFG_APU_BIT];
            nxt_st.cfgPdn     = cmdParam[`SWML_CFG_PDN_BIT];
            nxt_st.cfgSpu     = cmdParam[`SWML_CFG_SPU_BIT];
            nxt_st.cfgOds     = cmdParam[`SWML_CFG_ODS_BIT];
            nxt_st.readPtr    = `SWML_PTR_CONFIG;
            nxt_st.cmdAck     = 1'b1;
            nxt_st.cfgWritten = 1'b1;
            if (!cmdParam[`SWML_CFG_SPU_BIT])
              strongEnd = 1'b1;
          end
          else
          begin
            nxt_st.cmdNack = 1'b1;
          end
        end
        `SWML_CMD_SET_PTR:
        begin
          nxt_st.cmdAck = 1'b1;
          case (cmdParam)
            `SWML_PAR_CONFIG: nxt_st.readPtr = `SWML_PTR_CONFIG;
            `SWML_PAR_STATUS: nxt_st.readPtr = `SWML_PTR_STATUS;
            `SWML_PAR_RDATA:  nxt_st.readPtr = `SWML_PTR_RDATA;
            `SWML_PAR_PORT:   nxt_st.readPtr = `SWML_PTR_PORT;
            default:
            begin
              nxt_st.cmdAck  = 1'b0;
              nxt_st.cmdNack = 1'b1;
            end
          endcase
        end
        `SWML_CMD_ADJ_PORT:
        begin
          nxt_st.readPtr = `SWML_PTR_PORT;
          nxt_st.cmdAck  = 1'b1;
        end
        `SWML_CMD_LINE_RST, `SWML_CMD_LINE_BIT,
        `SWML_CMD_LINE_WRB, `SWML_CMD_LINE_RDB:
        begin
          // No line traffic while powered down
          if (st_ff.cfgPdn || !sleepN)
            nxt_st.cmdNack = 1'b1;
          else
          begin
            nxt_st.cmdAck  = 1'b1;
            nxt_st.lineGo  = 1'b1;
            nxt_st.readPtr = `SWML_PTR_STATUS;
          end
        end
        `SWML_CMD_DEV_RESET:
        begin
          nxt_st.cmdAck  = 1'b1;
          nxt_st.readPtr = `SWML_PTR_STATUS;
        end
        default:
        begin
          nxt_st.cmdNack = 1'b1;
        end
      endcase
    end

    if (cmdLine && !st_ff.cfgPdn && sleepN)
      strongEnd = 1'b1;

    // ==========================================================
    // Pullup transistor control
    case (st_ff.puState)
      PU_IDLE:
      begin
        nxt_st.puCount = 8'h00;
        if (!shortRecovery)
        begin
          if (resetRiseStart && st_ff.cfgApu)
            nxt_st.puState = PU_FIXED;
          else if (riseStart && st_ff.cfgSpu)
            nxt_st.puState = PU_SWAIT;
          else if (riseStart && st_ff.cfgApu)
            nxt_st.puState = PU_WAIT;
        end
      end
      PU_WAIT:
      begin
        if (slotEnd || shortRecovery)
          nxt_st.puState = PU_IDLE;
        else if (apuAbove)
          nxt_st.puState = PU_ACTIVE;
      end
      PU_ACTIVE:
      begin
        if (slotEnd)
          nxt_st.puState = PU_IDLE;
      end
      PU_FIXED:
      begin
        nxt_st.puCount = st_ff.puCount + 8'h01;
        if (st_ff.puCount == fixedLen - 8'h01)
          nxt_st.puState = PU_IDLE;
      end
      PU_SWAIT:
      begin
        if (shortRecovery)
          nxt_st.puState = PU_IDLE;
        else if (st_ff.cfgApu ? apuAbove : vihAbove)
          nxt_st.puState = PU_STRONG;
      end
      PU_STRONG:
      begin
        nxt_st.puState = PU_STRONG;
      end
      default:
      begin
        nxt_st.puState = PU_IDLE;
      end
    endcase

    // Strong pullup end clears its bit only
    if (strongEnd && (st_ff.puState == PU_STRONG || st_ff.puState == PU_SWAIT))
    begin
      nxt_st.puState = PU_IDLE;
      if (!(cmdValid && cmdCode == `SWML_CMD_WRITE_CFG))
        nxt_st.cfgSpu = 1'b0;
    end

    if (nxt_st.cfgPdn)
      nxt_st.puState = PU_IDLE;

    if (cmdReset)
    begin
      nxt_st.cfgApu    = 1'b0;
      nxt_st.cfgPdn    = 1'b0;
      nxt_st.cfgSpu    = 1'b0;
      nxt_st.cfgOds    = 1'b0;
      nxt_st.puState   = PU_IDLE;
      nxt_st.puCount   = 8'h00;
      nxt_st.lineAbort = 1'b1;
    end

    // ==========================================================
    // Line outputs
    // Power-down bit set: resistor off, line held low
    nxt_st.resistorOn = !nxt_st.cfgPdn;
    nxt_st.holdLow    = nxt_st.cfgPdn;
    nxt_st.xtorOn     = (nxt_st.puState == PU_ACTIVE) || (nxt_st.puState == PU_FIXED) ||
                        (nxt_st.puState == PU_STRONG);
    nxt_st.sleeping   = !st_ff.sleepNSync[1];
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      st_ff            <= '0;
      st_ff.cfgApu     <= cfgResetVal[`SWML_CFG_APU_BIT];
      st_ff.cfgPdn     <= cfgResetVal[`SWML_CFG_PDN_BIT];
      st_ff.cfgSpu     <= cfgResetVal[`SWML_CFG_SPU_BIT];
      st_ff.cfgOds     <= cfgResetVal[`SWML_CFG_ODS_BIT];
      st_ff.readPtr    <= `SWML_PTR_STATUS;
      st_ff.puState    <= PU_IDLE;
      st_ff.apuThrSync <= 2'h0;
      st_ff.vihThrSync <= 2'h0;
      st_ff.sleepNSync <= 2'h3;
      st_ff.resistorOn <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign cmdAck               = st_ff.cmdAck;
  assign cmdNack              = st_ff.cmdNack;
  assign rdData               = st_ff.rdData;
  assign readPtr              = st_ff.readPtr;
  assign lineGo               = st_ff.lineGo;
  assign lineAbort            = st_ff.lineAbort;
  assign overdriveSpeedSelect = st_ff.cfgOds;
  assign cfgWritten           = st_ff.cfgWritten;
  assign linePullupResistor   = st_ff.resistorOn;
  assign pullupTransistorOn   = st_ff.xtorOn;
  assign lineHoldLow          = st_ff.holdLow;
  assign deviceSleep          = st_ff.sleeping;

endmodule

// ### tb/swml_line_config_sva.sv
`timescale 1ns/1ns
`include "swml_regs.svh"
module swml_line_config_sva
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // Command and read ports
  input wire logic       cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] cmdParam,
  input wire logic       cmdAck,
  input wire logic       cmdNack,
  input wire logic       rdStrobe,
  input wire logic [7:0] statusIn,
  input wire logic [7:0] rdData,
  input wire logic [1:0] readPtr,
  // Line side
  input wire logic       lineGo,
  input wire logic       lineAbort,
  input wire logic       overdriveSpeedSelect,
  input wire logic       cfgWritten,
  input wire logic       linePullupResistor,
  input wire logic       pullupTransistorOn,
  input wire logic       lineHoldLow,
  input wire logic       sleepNInput,
  input wire logic       deviceSleep
);
  wire logic isCfg  = cmdValid && cmdCode == `SWML_CMD_WRITE_CFG;
  wire logic nibOk  = cmdParam[7:4] == ~cmdParam[3:0];
  wire logic newOds = cmdParam[`SWML_CFG_ODS_BIT];
  wire logic isLine = cmdValid && cmdCode inside {[`SWML_CMD_LINE_RST:`SWML_CMD_LINE_RDB]};
  wire logic isRst  = cmdValid && cmdCode == `SWML_CMD_DEV_RESET;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_answer; cmdValid |=> cmdAck != cmdNack; endproperty
  a_answer: assert property (p_answer)
    else $error("command answer count wrong");
  property p_cfg_ok; isCfg && nibOk |=> cmdAck && cfgWritten && readPtr == 2'h0
    && overdriveSpeedSelect == $past(newOds); endproperty
  a_cfg_ok: assert property (p_cfg_ok)
    else $error("good config write not taken");
  property p_cfg_bad; isCfg && !nibOk |=> cmdNack && !cfgWritten
    && $stable(overdriveSpeedSelect); endproperty
  a_cfg_bad: assert property (p_cfg_bad)
    else $error("bad config write changed state");
  property p_rd_cfg; rdStrobe && !cmdValid && readPtr == 2'h0 |=> rdData[7:4] == 4'h0; endproperty
  a_rd_cfg: assert property (p_rd_cfg)
    else $error("config upper nibble not zero");
  property p_rd_stat; rdStrobe && !cmdValid && readPtr == 2'h1 |=> rdData == $past(statusIn);
  endproperty
  a_rd_stat: assert property (p_rd_stat)
    else $error("status read wrong");
  property p_dev_rst; isRst |=> lineAbort && !overdriveSpeedSelect ##[0:1] cmdAck; endproperty
  a_dev_rst: assert property (p_dev_rst)
    else $error("device reset command not obeyed");
  property p_pdn_pins; lineHoldLow |-> !linePullupResistor && !pullupTransistorOn; endproperty
  a_pdn_pins: assert property (p_pdn_pins)
    else $error("power-down pins wrong");
  property p_pdn_ref; lineHoldLow && !$past(cmdValid) && isLine |=> cmdNack && !lineGo;
  endproperty
  a_pdn_ref: assert property (p_pdn_ref)
    else $error("line command taken in power-down");
  property p_sleep; !sleepNInput [*5] |-> deviceSleep; endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not entered");
  property p_sleep_pins; deviceSleep && !lineHoldLow |-> linePullupResistor; endproperty
  a_sleep_pins: assert property (p_sleep_pins)
    else $error("resistor off while asleep");
  c_cfg: cover property (isCfg && nibOk);
  c_xtor: cover property ($rose(pullupTransistorOn));
  c_pdn_sleep: cover property (lineHoldLow && deviceSleep);
endmodule
bind swml_line_config swml_line_config_sva chk_u
(
  .clock(clock), .reset(reset), .cmdValid(cmdValid), .cmdCode(cmdCode),
  .cmdParam(cmdParam), .cmdAck(cmdAck), .cmdNack(cmdNack), .rdStrobe(rdStrobe),
  .statusIn(statusIn), .rdData(rdData), .readPtr(readPtr), .lineGo(lineGo),
  .lineAbort(lineAbort), .overdriveSpeedSelect(overdriveSpeedSelect),
  .cfgWritten(cfgWritten), .linePullupResistor(linePullupResistor),
  .pullupTransistorOn(pullupTransistorOn), .lineHoldLow(lineHoldLow),
  .sleepNInput(sleepNInput), .deviceSleep(deviceSleep)
);

// ### tb/swml_line_partner.sv
`timescale 1ns/1ns
module swml_line_partner
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Scenario controls
  input  wire logic doReset,
  input  wire logic slow,
  // Master side
  input  wire logic lineGo,
  input  wire logic resistorOn,
  input  wire logic holdLow,
  // Line events and comparator level
  output logic      riseStart,
  output logic      resetRiseStart,
  output logic      slotEnd,
  output logic      lineHigh
);
  logic [4:0] slotCnt_ff;
  always_ff @(posedge clock)
  begin
    if (reset)
      slotCnt_ff <= 5'h00;
    else if (lineGo)
      slotCnt_ff <= 5'h01;
    else if (slotCnt_ff == 5'h14)
      slotCnt_ff <= 5'h00;
    else if (slotCnt_ff != 5'h00)
      slotCnt_ff <= slotCnt_ff + 5'h01;
  end
  assign riseStart = slotCnt_ff == 5'h02 && !doReset;
  assign resetRiseStart = slotCnt_ff == 5'h02 && doReset;
  assign slotEnd = slotCnt_ff == 5'h10;
  assign lineHigh = resistorOn && !holdLow
    && (slotCnt_ff == 5'h00 || slotCnt_ff > (slow ? 5'h08 : 5'h04));
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ns
`include "swml_regs.svh"
module tb_top;
  logic       clock, reset, cmdValid, rdStrobe, shortRecovery, sleepNInput, doReset, slow;
  logic [7:0] cmdCode, cmdParam, statusIn, readDataIn, portCfgIn, rdData;
  logic       cmdAck, cmdNack, lineGo, lineAbort, ods, cfgWritten, res, xtor, holdLow;
  logic       devSleep, riseStart, resetRiseStart, slotEnd, lineHigh;
  logic [1:0] readPtr;
  int         fails, tests_run, onCnt;
  swml_line_config dut_u
  (
    .clock(clock), .reset(reset), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdParam(cmdParam), .cmdAck(cmdAck), .cmdNack(cmdNack), .rdStrobe(rdStrobe),
    .statusIn(statusIn), .readDataIn(readDataIn), .portCfgIn(portCfgIn), .rdData(rdData),
    .readPtr(readPtr), .riseStart(riseStart), .resetRiseStart(resetRiseStart),
    .slotEnd(slotEnd), .shortRecovery(shortRecovery), .lineGo(lineGo),
    .lineAbort(lineAbort), .overdriveSpeedSelect(ods), .cfgWritten(cfgWritten),
    .activePullupThreshold(lineHigh), .inputHighThreshold(lineHigh),
    .sleepNInput(sleepNInput), .linePullupResistor(res), .pullupTransistorOn(xtor),
    .lineHoldLow(holdLow), .deviceSleep(devSleep)
  );
  swml_line_partner far_u
  (
    .clock(clock), .reset(reset), .doReset(doReset), .slow(slow), .lineGo(lineGo),
    .resistorOn(res), .holdLow(holdLow), .riseStart(riseStart),
    .resetRiseStart(resetRiseStart), .slotEnd(slotEnd), .lineHigh(lineHigh)
  );
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
    if (xtor === 1'b1)
      onCnt++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] par, input logic ack);
    @(negedge clock);
    cmdValid = 1'b1;
    cmdCode = code;
    cmdParam = par;
    @(negedge clock);
    cmdValid = 1'b0;
    chk({6'h00, cmdAck, cmdNack}, {6'h00, ack, ~ack});
  endtask
  task automatic wcfg(input logic [3:0] v);
    cmd(`SWML_CMD_WRITE_CFG, {~v, v}, 1'b1);
  endtask
  task automatic rd(input logic [7:0] exp);
    @(negedge clock);
    rdStrobe = 1'b1;
    @(negedge clock);
    rdStrobe = 1'b0;
    @(negedge clock);
    chk(rdData, exp);
  endtask
  task automatic slot(input logic [7:0] code, input int cyc);
    onCnt = 0;
    cmd(code, 8'h00, 1'b1);
    repeat (cyc) @(negedge clock);
  endtask
  task automatic test_done();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clock);
    $display("mismatch at %0t: watchdog timeout", $time);
    fails++;
    test_done();
  end
  initial
  begin
    {reset, doReset, sleepNInput} = 3'b101;
    {cmdValid, rdStrobe, shortRecovery, slow} = 4'h0;
    {cmdCode, cmdParam} = 16'h0000;
    {statusIn, readDataIn, portCfgIn} = 24'h5AC609;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    chk({3'h0, readPtr, res, holdLow, ods}, 8'h0C);
    cmd(`SWML_CMD_SET_PTR, `SWML_PAR_CONFIG, 1'b1);
    rd(8'h00);
    cmd(`SWML_CMD_SET_PTR, `SWML_PAR_RDATA, 1'b1);
    rd(8'hC6);
    cmd(`SWML_CMD_SET_PTR, `SWML_PAR_PORT, 1'b1);
    rd(8'h09);
    cmd(`SWML_CMD_SET_PTR, 8'h34, 1'b0);
    cmd(8'h00, 8'h00, 1'b0);
    for (int v = 1; v < 16; v += 4)
    begin
      wcfg(4'(v));
      rd({4'h0, 4'(v)});
    end
    wcfg(4'h9);
    cmd(`SWML_CMD_WRITE_CFG, 8'h99, 1'b0);
    rd(8'h09);
    chk({7'h00, ods}, 8'h01);
    slow = 1'b1;
    slot(`SWML_CMD_LINE_BIT, 30);
    chk({7'h00, onCnt > 0 && xtor === 1'b0}, 8'h01);
    slow = 1'b0;
    shortRecovery = 1'b1;
    slot(`SWML_CMD_LINE_BIT, 30);
    chk(8'(onCnt), 8'h00);
    shortRecovery = 1'b0;
    wcfg(4'h8);
    slot(`SWML_CMD_LINE_WRB, 30);
    chk(8'(onCnt), 8'h00);
    doReset = 1'b1;
    wcfg(4'h9);
    slot(`SWML_CMD_LINE_RST, 60);
    chk(8'(onCnt), 8'(`SWML_FIXED_OD_CYC));
    wcfg(4'h1);
    slot(`SWML_CMD_LINE_RST, 160);
    chk(8'(onCnt), 8'(`SWML_FIXED_STD_CYC));
    doReset = 1'b0;
    wcfg(4'h5);
    slot(`SWML_CMD_LINE_WRB, 40);
    chk({7'h00, xtor}, 8'h01);
    slot(`SWML_CMD_LINE_BIT, 30);
    cmd(`SWML_CMD_SET_PTR, `SWML_PAR_CONFIG, 1'b1);
    rd(8'h01);
    wcfg(4'h4);
    slot(`SWML_CMD_LINE_WRB, 30);
    chk({7'h00, xtor}, 8'h01);
    wcfg(4'h0);
    repeat (3) @(negedge clock);
    chk({7'h00, xtor}, 8'h00);
    wcfg(4'h2);
    repeat (2) @(negedge clock);
    chk({5'h00, res, holdLow, xtor}, 8'h02);
    cmd(`SWML_CMD_LINE_BIT, 8'h00, 1'b0);
    sleepNInput = 1'b0;
    repeat (6) @(negedge clock);
    chk({6'h00, devSleep, holdLow}, 8'h03);
    wcfg(4'h0);
    repeat (3) @(negedge clock);
    chk({5'h00, devSleep, res, holdLow}, 8'h06);
    cmd(`SWML_CMD_LINE_RST, 8'h00, 1'b0);
    sleepNInput = 1'b1;
    repeat (5) @(negedge clock);
    wcfg(4'h8);
    cmd(`SWML_CMD_LINE_BIT, 8'h00, 1'b1);
    cmd(`SWML_CMD_DEV_RESET, 8'h00, 1'b1);
    chk({6'h00, readPtr}, 8'h01);
    rd(8'h5A);
    cmd(`SWML_CMD_SET_PTR, `SWML_PAR_CONFIG, 1'b1);
    rd(8'h00);
    wcfg(4'h8);
    wcfg(4'h0);
    slot(`SWML_CMD_LINE_RST, 30);
    chk({7'h00, ods}, 8'h00);
    test_done();
  end
endmodule
